/* include/bss_pkg.sv */
// constants, field layout and types of the bridge secondary-side status block
package bss_pkg;

   // register bus geometry
   localparam int BSS_ADDR_W = 8;
   localparam int BSS_DATA_W = 32;
   localparam int BSS_BE_W = 4;

   // byte addresses of the two words this block answers
   localparam logic [7:0] BSS_OFF_SEC_STATUS = 8'h1C;
   localparam logic [7:0] BSS_OFF_BRIDGE_CTRL = 8'h3C;

   // bit positions inside the 32-bit word at BSS_OFF_SEC_STATUS
   localparam int BSS_BIT_RSVD_LO = 16;
   localparam int BSS_RSVD_LO_W = 5;
   localparam int BSS_BIT_CAP66 = 21;
   localparam int BSS_BIT_RSVD22 = 22;
   localparam int BSS_BIT_FAST_B2B = 23;
   localparam int BSS_BIT_MDPE = 24;
   localparam int BSS_BIT_SEL_TIM_LO = 25;
   localparam int BSS_BIT_SEL_TIM_HI = 26;
   localparam int BSS_BIT_SIG_TABORT = 27;
   localparam int BSS_BIT_RCV_TABORT = 28;
   localparam int BSS_BIT_RCV_MABORT = 29;
   localparam int BSS_BIT_RCV_SERR = 30;
   localparam int BSS_BIT_DET_PERR = 31;

   // bit position of the parity error response enable in the bridge control word
   localparam int BSS_BIT_PERR_RESP_EN = 16;

   // byte lanes that carry the status flag byte and the control enable
   localparam int BSS_LANE_STATUS_HI = 3;
   localparam int BSS_LANE_CTRL = 2;

   // index of each sticky event flag in the flag bank
   localparam int BSS_NUM_FLAGS = 6;
   localparam int BSS_FL_MDPE = 0;
   localparam int BSS_FL_SIG_TABORT = 1;
   localparam int BSS_FL_RCV_TABORT = 2;
   localparam int BSS_FL_RCV_MABORT = 3;
   localparam int BSS_FL_RCV_SERR = 4;
   localparam int BSS_FL_DET_PERR = 5;

   // target select timing codes
   localparam logic [1:0] BSS_SEL_TIM_MEDIUM = 2'h1;
   localparam logic [1:0] BSS_SEL_TIM_NONE = 2'h0;

   // reset values
   localparam logic [31:0] BSS_RDATA_RST = 32'h0000_0000;
   localparam logic [5:0] BSS_FLAGS_RST = 6'h00;
   localparam logic BSS_PERR_EN_RST = 1'b0;

   // bus handshake state
   typedef enum logic [0:0] {
      BSS_IDLE = 1'b0,
      BSS_ACK = 1'b1
   } bss_bus_st_t;

endpackage

/* verilog/bss_flag_bank.sv */
// bank of sticky event flags: hardware sets, software writes one to clear
`timescale 1ns/10ps
module bss_flag_bank
   import bss_pkg::*;
#(
   parameter int WIDTH = BSS_NUM_FLAGS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] set_ev,
   input wire logic [WIDTH-1:0] clr_ev,
   output logic [WIDTH-1:0] flags_q
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } bss_bank_t;

   bss_bank_t st_q;
   bss_bank_t st_d;
   logic [WIDTH-1:0] nxt;

   // per flag: a set in the clearing cycle wins so no event is lost
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         assign nxt[i] = set_ev[i] | (st_q.flags[i] & ~clr_ev[i]);
      end
   endgenerate

   // next state
   always_comb begin
      st_d = st_q;
      st_d.flags = nxt;
   end

   // all flags return to zero at reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q.flags <= WIDTH'(BSS_FLAGS_RST);
      end else begin
         st_q <= st_d;
      end
   end

   assign flags_q = st_q.flags;

endmodule

/* verilog/bss_status.sv */
// secondary-side status half-word and parity response enable, Avalon-MM slave
//
// How it works
// - bit 21 read-only: 1 in forward mode, 0 in reverse mode.
// - bit 23 reads 1 only forward with conventional PCI secondary, else 0.
// - bit 24 sets only while parity response enable is on and a condition hits.
// - forward: parity error on read data or read split response sets bit 24.
// - forward: secondary parity pin low during write data or write split sets 24.
// - forward: split completion message reporting write data parity error sets 24.
// - reverse: poisoned completion received or poisoned write issued sets 24.
// - bits 26:25 read-only: 01 in forward mode, 00 in reverse mode.
// - forward: bridge signalling target abort sets bit 27.
// - reverse: bridge completing with completer abort status sets bit 27.
// - forward: target abort detected on the secondary sets bit 28.
// - reverse: completer abort completion received on the secondary sets bit 28.
// - forward: master abort detected on the secondary sets bit 29.
// - reverse: unsupported request completion received on primary sets bit 29.
// - forward: system error pin low on the secondary sets bit 30.
// - reverse: fatal or non-fatal error message on the secondary sets bit 30.
// - forward: address or data parity error on the secondary sets bit 31.
// - reverse: poisoned packet arriving on the secondary sets bit 31.
// - bridge control bit 16 enables parity response; zero keeps bit 24 from setting, bit 31 still sets.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
module bss_status
   import bss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   // mode straps, caught while reset is held
   input wire logic forward_mode,
   input wire logic sec_pcix_mode,
   // Avalon-MM slave
   input wire logic [BSS_ADDR_W-1:0] avm_address,
   input wire logic avm_read,
   input wire logic avm_write,
   input wire logic [BSS_DATA_W-1:0] avm_writedata,
   input wire logic [BSS_BE_W-1:0] avm_byteenable,
   output logic [BSS_DATA_W-1:0] avm_readdata,
   output logic avm_waitrequest,
   // secondary bus pins, active low, synchronous to ref_clk
   input wire logic secondary_parity_err_n,
   input wire logic system_error_n,
   // high while sending write data or taking a split response for a write
   input wire logic sec_write_phase,
   // forward mode event pulses
   input wire logic fwd_read_parity_err,
   input wire logic fwd_split_msg_perr,
   input wire logic fwd_target_abort_sent,
   input wire logic fwd_target_abort_rcvd,
   input wire logic fwd_master_abort_rcvd,
   input wire logic fwd_addr_data_perr,
   // reverse mode event pulses
   input wire logic rev_poisoned_cpl_rcvd,
   input wire logic rev_poisoned_wr_sent,
   input wire logic rev_ca_cpl_sent,
   input wire logic rev_ca_cpl_rcvd,
   input wire logic rev_ur_cpl_rcvd,
   input wire logic rev_err_msg_rcvd,
   input wire logic rev_poisoned_tlp_rcvd,
   // parity response enable, for the datapath that reports parity errors
   output logic parity_resp_en
);

   // all block state except the sticky flags in one record
   typedef struct packed {
      bss_bus_st_t bus_st;
      logic wait_req;
      logic [BSS_DATA_W-1:0] rdata;
      logic fwd;
      logic pcix;
      logic perr_en;
   } bss_state_t;

   bss_state_t st_q;
   bss_state_t st_d;

   logic [BSS_NUM_FLAGS-1:0] flags;
   logic [BSS_NUM_FLAGS-1:0] set_ev;
   logic [BSS_NUM_FLAGS-1:0] clr_ev;
   logic [BSS_DATA_W-1:0] status_word;
   logic [BSS_DATA_W-1:0] ctrl_word;
   logic [BSS_DATA_W-1:0] rd_mux;
   logic wr_take;
   logic rev;
   logic mdpe_fwd;
   logic mdpe_rev;

   // word decode, shared by the read mux and the write strobes
   function automatic logic bss_hit(input logic [BSS_ADDR_W-1:0] addr,
                                    input logic [BSS_ADDR_W-1:0] off);
      bss_hit = (addr[BSS_ADDR_W-1:2] == off[BSS_ADDR_W-1:2]);
   endfunction

   assign rev = ~st_q.fwd;

   // write takes effect only on the edge where waitrequest is low
   assign wr_take = avm_write && (st_q.bus_st == BSS_ACK);

   // master data parity conditions per mode, before the enable gate
   always_comb begin
      mdpe_fwd = 1'b0;
      mdpe_rev = 1'b0;
      mdpe_fwd = fwd_read_parity_err
         | (~secondary_parity_err_n & sec_write_phase)
         | fwd_split_msg_perr;
      mdpe_rev = rev_poisoned_cpl_rcvd | rev_poisoned_wr_sent;
   end

   // event sources; forward-side events count only in forward mode and
   // reverse-side events only in reverse mode, so a stray pulse from the
   // unused datapath cannot raise a flag
   always_comb begin
      set_ev = '0;
      set_ev[BSS_FL_MDPE] = st_q.perr_en &
         ((st_q.fwd & mdpe_fwd) | (rev & mdpe_rev));
      set_ev[BSS_FL_SIG_TABORT] =
         (st_q.fwd & fwd_target_abort_sent)
         | (rev & rev_ca_cpl_sent);
      set_ev[BSS_FL_RCV_TABORT] =
         (st_q.fwd & fwd_target_abort_rcvd)
         | (rev & rev_ca_cpl_rcvd);
      set_ev[BSS_FL_RCV_MABORT] =
         (st_q.fwd & fwd_master_abort_rcvd)
         | (rev & rev_ur_cpl_rcvd);
      set_ev[BSS_FL_RCV_SERR] =
         (st_q.fwd & ~system_error_n)
         | (rev & rev_err_msg_rcvd);
      set_ev[BSS_FL_DET_PERR] =
         (st_q.fwd & fwd_addr_data_perr)
         | (rev & rev_poisoned_tlp_rcvd);
   end

   // write-one-to-clear strobes; all flags sit in the top byte lane
   always_comb begin
      clr_ev = '0;
      if (wr_take && bss_hit(avm_address, BSS_OFF_SEC_STATUS) &&
          avm_byteenable[BSS_LANE_STATUS_HI]) begin
         clr_ev[BSS_FL_MDPE] = avm_writedata[BSS_BIT_MDPE];
         clr_ev[BSS_FL_SIG_TABORT] = avm_writedata[BSS_BIT_SIG_TABORT];
         clr_ev[BSS_FL_RCV_TABORT] = avm_writedata[BSS_BIT_RCV_TABORT];
         clr_ev[BSS_FL_RCV_MABORT] = avm_writedata[BSS_BIT_RCV_MABORT];
         clr_ev[BSS_FL_RCV_SERR] = avm_writedata[BSS_BIT_RCV_SERR];
         clr_ev[BSS_FL_DET_PERR] = avm_writedata[BSS_BIT_DET_PERR];
      end
   end

   // sticky flags
   bss_flag_bank #(
      .WIDTH(BSS_NUM_FLAGS)
   ) u_flags (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .set_ev(set_ev),
      .clr_ev(clr_ev),
      .flags_q(flags)
   );

   // status word; the low half-word belongs to other registers and reads zero
   always_comb begin
      status_word = '0;
      status_word[BSS_BIT_RSVD_LO +: BSS_RSVD_LO_W] = '0;
      status_word[BSS_BIT_CAP66] = st_q.fwd;
      status_word[BSS_BIT_RSVD22] = 1'b0;
      status_word[BSS_BIT_FAST_B2B] = st_q.fwd & ~st_q.pcix;
      status_word[BSS_BIT_MDPE] = flags[BSS_FL_MDPE];
      if (st_q.fwd) begin
         status_word[BSS_BIT_SEL_TIM_HI:BSS_BIT_SEL_TIM_LO] = BSS_SEL_TIM_MEDIUM;
      end else begin
         status_word[BSS_BIT_SEL_TIM_HI:BSS_BIT_SEL_TIM_LO] = BSS_SEL_TIM_NONE;
      end
      status_word[BSS_BIT_SIG_TABORT] = flags[BSS_FL_SIG_TABORT];
      status_word[BSS_BIT_RCV_TABORT] = flags[BSS_FL_RCV_TABORT];
      status_word[BSS_BIT_RCV_MABORT] = flags[BSS_FL_RCV_MABORT];
      status_word[BSS_BIT_RCV_SERR] = flags[BSS_FL_RCV_SERR];
      status_word[BSS_BIT_DET_PERR] = flags[BSS_FL_DET_PERR];
   end

   // bridge control word: only the parity response enable lives here
   always_comb begin
      ctrl_word = '0;
      ctrl_word[BSS_BIT_PERR_RESP_EN] = st_q.perr_en;
   end

   // read mux; an unmapped address reads zero rather than stalling the bus
   always_comb begin
      rd_mux = '0;
      if (bss_hit(avm_address, BSS_OFF_SEC_STATUS)) begin
         rd_mux = status_word;
      end else if (bss_hit(avm_address, BSS_OFF_BRIDGE_CTRL)) begin
         rd_mux = ctrl_word;
      end
   end

   // bus handshake: every request waits one cycle, then is answered;
   // the fixed latency costs a cycle but keeps the read data registered
   always_comb begin
      st_d = st_q;
      unique case (st_q.bus_st)
         BSS_IDLE: begin
            if (avm_read || avm_write) begin
               st_d.bus_st = BSS_ACK;
               st_d.wait_req = 1'b0;
               if (avm_read) begin
                  st_d.rdata = rd_mux;
               end
            end
         end
         BSS_ACK: begin
            st_d.bus_st = BSS_IDLE;
            st_d.wait_req = 1'b1;
            if (wr_take && bss_hit(avm_address, BSS_OFF_BRIDGE_CTRL) &&
                avm_byteenable[BSS_LANE_CTRL]) begin
               st_d.perr_en = avm_writedata[BSS_BIT_PERR_RESP_EN];
            end
         end
      endcase
      // straps are captured during reset and held afterwards
      if (sys_rst) begin
         st_d.bus_st = BSS_IDLE;
         st_d.wait_req = 1'b1;
         st_d.rdata = BSS_RDATA_RST;
         st_d.fwd = forward_mode;
         st_d.pcix = sec_pcix_mode;
         st_d.perr_en = BSS_PERR_EN_RST;
      end
   end

   // one register stage for all state except the sticky flags
   always_ff @(posedge ref_clk) begin
      st_q <= st_d;
   end

   assign avm_readdata = st_q.rdata;
   assign avm_waitrequest = st_q.wait_req;
   assign parity_resp_en = st_q.perr_en;

endmodule

/* bench/bss_far_side.sv */
// far-side agents: bus pins and link event pulses driven on bench request
`timescale 1ns/10ps
module bss_far_side (
   input wire logic [15:0] ev,
   output logic perr_n,
   output logic serr_n,
   output logic wphase,
   output logic [12:0] pulse
);
   // pins have pull-ups, so they rest high between events; ev[15] pulls the
   // parity pin outside a write phase, which must not count
   assign perr_n = ~(ev[0] | ev[15]);
   // idle cycles sit in a long clean write, so the phase alone is exercised
   assign wphase = ev[0] | ~|ev;
   assign serr_n = ~ev[1];
   assign pulse = ev[14:2];
endmodule

/* bench/bss_properties.sv */
// concurrent checks on the status block's bus answer and readback
`timescale 1ns/10ps
module bss_properties
   import bss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic forward_mode,
   input wire logic sec_pcix_mode,
   input wire logic [BSS_ADDR_W-1:0] avm_address,
   input wire logic avm_read,
   input wire logic avm_write,
   input wire logic [BSS_DATA_W-1:0] avm_writedata,
   input wire logic [BSS_BE_W-1:0] avm_byteenable,
   input wire logic [BSS_DATA_W-1:0] avm_readdata,
   input wire logic avm_waitrequest,
   input wire logic system_error_n,
   input wire logic fwd_read_parity_err,
   input wire logic parity_resp_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // request taken while idle, answer stands exactly one cycle
   sequence s_req;
      (avm_read || avm_write) && avm_waitrequest;
   endsequence
   sequence s_ans;
      !avm_waitrequest ##1 avm_waitrequest;
   endsequence
   sequence s_rd;
      avm_read && !avm_waitrequest && avm_address[7:2] == BSS_OFF_SEC_STATUS[7:2];
   endsequence
   // $past must not reach back into reset
   sequence s_rd_old;
      s_rd ##0 (!$past(sys_rst) && !$past(sys_rst, 2));
   endsequence
   property p_ack;
      s_req |=> s_ans;
   endproperty
   property p_cap66;
      s_rd |-> avm_readdata[BSS_BIT_CAP66] == forward_mode;
   endproperty
   property p_b2b;
      s_rd |-> avm_readdata[BSS_BIT_FAST_B2B] == (forward_mode && !sec_pcix_mode);
   endproperty
   property p_seltim;
      s_rd |-> avm_readdata[26:25] == (forward_mode ? 2'h1 : 2'h0);
   endproperty
   property p_rsvd;
      s_rd |-> (avm_readdata[22:16] & 7'h5F) == 7'h00;
   endproperty
   property p_serr;
      s_rd_old ##0 $past(!system_error_n && forward_mode, 2) |-> avm_readdata[BSS_BIT_RCV_SERR];
   endproperty
   property p_mdpe;
      s_rd_old ##0 $past(fwd_read_parity_err && parity_resp_en && forward_mode, 2)
         |-> avm_readdata[BSS_BIT_MDPE];
   endproperty
   property p_perr_en;
      avm_write && !avm_waitrequest && avm_address[7:2] == BSS_OFF_BRIDGE_CTRL[7:2]
         && avm_byteenable[BSS_LANE_CTRL] |=> parity_resp_en == $past(avm_writedata[16]);
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer not one cycle");
   a_cap66: assert property (p_cap66) else $error("speed bit wrong");
   a_b2b: assert property (p_b2b) else $error("back to back bit wrong");
   a_seltim: assert property (p_seltim) else $error("select timing wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   a_serr: assert property (p_serr) else $error("system error flag missed");
   a_mdpe: assert property (p_mdpe) else $error("data parity flag missed");
   a_perr_en: assert property (p_perr_en) else $error("enable not written");
endmodule
bind bss_status bss_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .forward_mode(forward_mode), .sec_pcix_mode(sec_pcix_mode), .avm_address(avm_address),
   .avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
   .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata),
   .avm_waitrequest(avm_waitrequest), .system_error_n(system_error_n),
   .fwd_read_parity_err(fwd_read_parity_err), .parity_resp_en(parity_resp_en));

/* bench/tb_bridge_secondary_status.sv */
// self-checking bench for the secondary-side status block
`timescale 1ns/10ps
module tb_bridge_secondary_status
   import bss_pkg::*;
;
   logic ref_clk = 1'b0, sys_rst = 1'b1, fm = 1'b1, px = 1'b0;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0, wr = 1'b0, pre, wreq, perr_n, serr_n, wph;
   logic [31:0] wd = 32'h0000_0000, rdat;
   logic [3:0] be = 4'hF;
   logic [15:0] ev = 16'h0000;
   logic [12:0] pulse;
   int fails = 0, comparisons = 0;
   // flag bit hit by each event request, index as in the far-side model
   localparam int EB[16] = '{24, 30, 24, 24, 27, 28, 29, 31, 24, 24, 27, 28, 29, 30, 31, 24};
   always #10 ref_clk = ~ref_clk;
   bss_far_side far (.ev(ev), .perr_n(perr_n), .serr_n(serr_n), .wphase(wph), .pulse(pulse));
   bss_status dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .forward_mode(fm),
      .sec_pcix_mode(px), .avm_address(adr), .avm_read(rd), .avm_write(wr),
      .avm_writedata(wd), .avm_byteenable(be), .avm_readdata(rdat), .avm_waitrequest(wreq),
      .secondary_parity_err_n(perr_n), .system_error_n(serr_n), .sec_write_phase(wph),
      .fwd_read_parity_err(pulse[0]), .fwd_split_msg_perr(pulse[1]),
      .fwd_target_abort_sent(pulse[2]), .fwd_target_abort_rcvd(pulse[3]),
      .fwd_master_abort_rcvd(pulse[4]), .fwd_addr_data_perr(pulse[5]),
      .rev_poisoned_cpl_rcvd(pulse[6]), .rev_poisoned_wr_sent(pulse[7]),
      .rev_ca_cpl_sent(pulse[8]), .rev_ca_cpl_rcvd(pulse[9]), .rev_ur_cpl_rcvd(pulse[10]),
      .rev_err_msg_rcvd(pulse[11]), .rev_poisoned_tlp_rcvd(pulse[12]), .parity_resp_en(pre));
   // fixed bits of the status word plus the expected flags
   function automatic logic [31:0] exp_word(logic f, logic p, logic [31:0] fl);
      logic [31:0] w;
      w = fl;
      w[21] = f;
      w[23] = f & ~p;
      w[26:25] = f ? 2'h1 : 2'h0;
      return w;
   endfunction
   // inactive-mode events are ignored; bit 24 also needs the enable;
   // the parity pin outside a write phase (request 15) never counts
   function automatic logic hits(int k, logic f, logic en);
      return k != 15 && (k < 8 ? f : !f) && (EB[k] != 24 || en);
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // one Avalon access; holds everything until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] r);
      int n;
      n = 0;
      adr <= a; wd <= d; be <= b; rd <= !w; wr <= w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      r = rdat;
      if (n >= 50) fails++;
      rd <= 1'b0; wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, 4'hF, r);
      chk(n, r, e);
   endtask
   task automatic close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog, about five times the expected run
   initial begin
      repeat (10000) @(posedge ref_clk);
      fails++;
      close_out;
   end
   initial begin
      logic [31:0] r, d, fl;
      void'($urandom(32'hA140));
      // three strap settings: forward PCI, forward PCI-X, reverse
      for (int m = 0; m < 3; m++) begin
         sys_rst <= 1'b1; fm <= (m != 2); px <= (m == 1);
         repeat (10) @(posedge ref_clk);
         sys_rst <= 1'b0;
         repeat (2) @(posedge ref_clk);
         rdc("reset word", 8'h1C, exp_word(fm, px, 32'h0));
         rdc("reset ctrl", 8'h3C, 32'h0000_0000);
         for (int en = 0; en < 2; en++) begin
            d = $urandom;
            d[16] = en[0];
            bus(1'b1, 8'h3C, d, 4'hF, r);
            chk("enable", {31'h0, pre}, {31'h0, en[0]});
            bus(1'b1, 8'h3C, ~d, 4'hB, r);
            chk("enable lane off", {31'h0, pre}, {31'h0, en[0]});
            for (int k = 0; k < 16; k++) begin
               ev <= 16'h0001 << k;
               @(posedge ref_clk);
               ev <= 16'h0000;
               fl = hits(k, fm, en[0]) ? (32'h1 << EB[k]) : 32'h0;
               rdc("flag set", 8'h1C, exp_word(fm, px, fl));
               // zeros in bits 31:27 and 24 and a write with the lane off leave those flags alone; bits 26:25 get random bits
               bus(1'b1, 8'h1C, $urandom & 32'h06FF_FFFF, 4'hF, r);
               bus(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'h7, r);
               rdc("flag kept", 8'h1C, exp_word(fm, px, fl));
               bus(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'hF, r);
               rdc("flag clear", 8'h1C, exp_word(fm, px, 32'h0));
            end
         end
         bus(1'b1, 8'h40, $urandom, 4'hF, r);
         rdc("unmapped", 8'h40, 32'h0000_0000);
         // an abort on the very edge a clear lands must survive it; the flag is
         // left set so the next reset has something to clear
         fl = 32'h1 << EB[fm ? 6 : 12];
         fork
            bus(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'hF, r);
            begin
               @(posedge ref_clk);
               ev <= fm ? 16'h0040 : 16'h1000;
               @(posedge ref_clk);
               ev <= 16'h0000;
            end
         join
         rdc("set beats clear", 8'h1C, exp_word(fm, px, fl));
         $display("strap setting %0d done", m);
      end
      close_out;
   end
endmodule
